// File: hca_pkg.sv
package hca_pkg;

  // widths of the core
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int DADDR_W = 7;
  localparam int DMEM_DEPTH = 128;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int PM_WORDS_SMALL = 2048;
  localparam int PM_WORDS_LARGE = 4096;

  // data space addresses of the mapped special registers
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_PC_LOW = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_POINTER = 7'h04;
  localparam logic [6:0] ADDR_PC_LATCH = 7'h0a;

  // status byte bit positions
  localparam int STATUS_C_BIT = 0;
  localparam int STATUS_DC_BIT = 1;
  localparam int STATUS_Z_BIT = 2;

  // values after reset
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [13:0] NOP_WORD = 14'h0000;

  // instruction classes, bits 13:12
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;

  // byte operations, bits 11:8
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [3:0] OP_DECSZ = 4'hb;
  localparam logic [3:0] OP_RRC = 4'hc;
  localparam logic [3:0] OP_RLC = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INCSZ = 4'hf;
  localparam logic [7:0] SPEC_RETURN = 8'h08;

  // bit operations, bits 11:10
  localparam logic [1:0] BIT_CLR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_TSTC = 2'h2;
  localparam logic [1:0] BIT_TSTS = 2'h3;

  // literal operations, bits 11:10
  localparam logic [1:0] LIT_MOV = 2'h0;
  localparam logic [1:0] LIT_RET = 2'h1;
  localparam logic [1:0] LIT_LOGIC = 2'h2;
  localparam logic [1:0] LIT_ARITH = 2'h3;

  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} hca_phase_t;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC,
    ALU_DEC, ALU_RRC, ALU_RLC, ALU_SWAP, ALU_CLR, ALU_BCLR, ALU_BSET
  } hca_alu_op_t;

  typedef struct packed {
    logic zero_flag;
    logic nibble_overflow_flag;
    logic carry_flag;
  } hca_flags_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [6:0] rd_addr;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
  } hca_dbus_t;

endpackage

// File: hca_dmem.sv
`timescale 1ns/1ps
`default_nettype none

module hca_dmem #(
  parameter int DEPTH = hca_pkg::DMEM_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // data bus from the core
  input wire hca_pkg::hca_dbus_t dbus_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem_q [DEPTH];
  logic [7:0] rd_data_d;
  logic [7:0] rd_data_q;

  // depth must cover the whole direct address range
  if (DEPTH != (1 << hca_pkg::DADDR_W))
  begin : g_depth_check
    $error("hca_dmem depth must match the data address range");
  end

  // read data held until the next read strobe
  always_comb
  begin
    rd_data_d = rd_data_q;
    if (dbus_i.rd_en)
    begin
      rd_data_d = mem_q[dbus_i.rd_addr];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_data_q <= hca_pkg::BYTE_RESET;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

  // storage array, no reset
  always_ff @(posedge clk_i)
  begin
    if (dbus_i.wr_en)
    begin
      mem_q[dbus_i.wr_addr] <= dbus_i.wr_data;
    end
  end

  assign rd_data_o = rd_data_q;

endmodule

`default_nettype wire

// File: hca_core.sv
`timescale 1ns/1ps
`default_nettype none

module hca_core #(
  parameter int PM_WORDS = hca_pkg::PM_WORDS_LARGE
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // program memory bus
  output logic [$clog2(PM_WORDS)-1:0] pm_addr_o,
  input wire logic [13:0] pm_data_i,
  // core state
  output hca_pkg::hca_phase_t phase_o,
  output logic [7:0] w_o,
  output hca_pkg::hca_flags_t flags_o
);

  localparam int PM_AW = $clog2(PM_WORDS);

  // only the two documented program sizes are served
  if (PM_WORDS != hca_pkg::PM_WORDS_SMALL && PM_WORDS != hca_pkg::PM_WORDS_LARGE)
  begin : g_pm_check
    $error("hca_core program size must be 2048 or 4096 words");
  end

  hca_pkg::hca_phase_t phase_d, phase_q;
  logic [13:0] ir_d, ir_q;
  logic [12:0] pc_d, pc_q;
  logic [12:0] stack_d [hca_pkg::STACK_DEPTH];
  logic [12:0] stack_q [hca_pkg::STACK_DEPTH];
  logic [2:0] sp_d, sp_q;
  logic [7:0] w_d, w_q, fsr_d, fsr_q, sfr_val_d, sfr_val_q;
  logic [4:0] pclath_d, pclath_q;
  logic sfr_hit_d, sfr_hit_q;
  hca_pkg::hca_flags_t flags_d, flags_q;
  hca_pkg::hca_dbus_t dbus;
  hca_pkg::hca_alu_op_t alu_op;
  logic [7:0] dmem_rdata, file_val, op_a, res;
  logic [9:0] alu_out;
  logic [6:0] eff_addr;
  logic [2:0] bitn;
  logic is_sfr, use_lit, sel_w, wr_f, wr_w, upd_z, upd_cdc, upd_c;
  logic skip_zero, skip_clr, skip_set, is_goto, is_call, is_return;
  logic skip_now, pcl_write, flow_chg;

  // eight-bit unit returning {carry, nibble carry, result}
  function automatic logic [9:0] alu_fn(input hca_pkg::hca_alu_op_t op, input logic [7:0] a,
                                        input logic [7:0] b, input logic cin,
                                        input logic [2:0] bn);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] m;
    s = 9'h000;
    n = 5'h00;
    m = 8'h01 << bn;
    alu_fn = {2'b00, a};
    case (op)
      hca_pkg::ALU_ADD:
      begin
        s = {1'b0, a} + {1'b0, b};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        alu_fn = {s[8], n[4], s[7:0]};
      end
      hca_pkg::ALU_SUB:
      begin
        s = {1'b0, a} + {1'b0, ~b} + 9'h001;
        n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        alu_fn = {s[8], n[4], s[7:0]};
      end
      hca_pkg::ALU_AND: alu_fn = {2'b00, a & b};
      hca_pkg::ALU_IOR: alu_fn = {2'b00, a | b};
      hca_pkg::ALU_XOR: alu_fn = {2'b00, a ^ b};
      hca_pkg::ALU_COM: alu_fn = {2'b00, ~a};
      hca_pkg::ALU_INC: alu_fn = {2'b00, a + 8'h01};
      hca_pkg::ALU_DEC: alu_fn = {2'b00, a - 8'h01};
      hca_pkg::ALU_RRC: alu_fn = {a[0], 1'b0, cin, a[7:1]};
      hca_pkg::ALU_RLC: alu_fn = {a[7], 1'b0, a[6:0], cin};
      hca_pkg::ALU_SWAP: alu_fn = {2'b00, a[3:0], a[7:4]};
      hca_pkg::ALU_CLR: alu_fn = 10'h000;
      hca_pkg::ALU_BCLR: alu_fn = {2'b00, a & ~m};
      hca_pkg::ALU_BSET: alu_fn = {2'b00, a | m};
      default: alu_fn = {2'b00, a};
    endcase
  endfunction

  // decode of the executing word, fixed 14-bit format
  always_comb
  begin
    alu_op = hca_pkg::ALU_PASS;
    {use_lit, sel_w, wr_f, wr_w, upd_z, upd_cdc, upd_c} = 7'h00;
    {skip_zero, skip_clr, skip_set, is_goto, is_call, is_return} = 6'h00;
    case (ir_q[13:12])
      hca_pkg::CLS_BYTE:
      begin
        wr_f = ir_q[7];
        wr_w = ~ir_q[7];
        case (ir_q[11:8])
          hca_pkg::OP_MISC:
          begin
            wr_w = 1'b0;
            sel_w = ir_q[7];
            is_return = (ir_q[7:0] == hca_pkg::SPEC_RETURN);
          end
          hca_pkg::OP_CLR: alu_op = hca_pkg::ALU_CLR;
          hca_pkg::OP_SUB: alu_op = hca_pkg::ALU_SUB;
          hca_pkg::OP_DEC: alu_op = hca_pkg::ALU_DEC;
          hca_pkg::OP_IOR: alu_op = hca_pkg::ALU_IOR;
          hca_pkg::OP_AND: alu_op = hca_pkg::ALU_AND;
          hca_pkg::OP_XOR: alu_op = hca_pkg::ALU_XOR;
          hca_pkg::OP_ADD: alu_op = hca_pkg::ALU_ADD;
          hca_pkg::OP_MOV: alu_op = hca_pkg::ALU_PASS;
          hca_pkg::OP_COM: alu_op = hca_pkg::ALU_COM;
          hca_pkg::OP_INC: alu_op = hca_pkg::ALU_INC;
          hca_pkg::OP_DECSZ: alu_op = hca_pkg::ALU_DEC;
          hca_pkg::OP_RRC: alu_op = hca_pkg::ALU_RRC;
          hca_pkg::OP_RLC: alu_op = hca_pkg::ALU_RLC;
          hca_pkg::OP_SWAP: alu_op = hca_pkg::ALU_SWAP;
          hca_pkg::OP_INCSZ: alu_op = hca_pkg::ALU_INC;
          default: alu_op = hca_pkg::ALU_PASS;
        endcase
        // flag and skip enables per byte operation
        upd_z = ir_q[11:8] inside {hca_pkg::OP_CLR, hca_pkg::OP_SUB, hca_pkg::OP_DEC,
                                   hca_pkg::OP_IOR, hca_pkg::OP_AND, hca_pkg::OP_XOR,
                                   hca_pkg::OP_ADD, hca_pkg::OP_MOV, hca_pkg::OP_COM,
                                   hca_pkg::OP_INC};
        upd_cdc = ir_q[11:8] == hca_pkg::OP_SUB || ir_q[11:8] == hca_pkg::OP_ADD;
        upd_c = ir_q[11:8] == hca_pkg::OP_RRC || ir_q[11:8] == hca_pkg::OP_RLC;
        skip_zero = ir_q[11:8] == hca_pkg::OP_DECSZ || ir_q[11:8] == hca_pkg::OP_INCSZ;
      end
      hca_pkg::CLS_BIT:
      begin
        wr_f = ~ir_q[11]; // clear and set write back, tests only read
        case (ir_q[11:10])
          hca_pkg::BIT_CLR: alu_op = hca_pkg::ALU_BCLR;
          hca_pkg::BIT_SET: alu_op = hca_pkg::ALU_BSET;
          hca_pkg::BIT_TSTC: skip_clr = 1'b1;
          default: skip_set = 1'b1;
        endcase
      end
      hca_pkg::CLS_JUMP: {is_call, is_goto} = {~ir_q[11], ir_q[11]};
      default:
      begin
        use_lit = 1'b1;
        wr_w = 1'b1;
        case (ir_q[11:10])
          hca_pkg::LIT_MOV: alu_op = hca_pkg::ALU_PASS;
          hca_pkg::LIT_RET: is_return = 1'b1;
          hca_pkg::LIT_LOGIC:
          begin
            upd_z = 1'b1;
            case (ir_q[9:8])
              2'h0: alu_op = hca_pkg::ALU_IOR;
              2'h1: alu_op = hca_pkg::ALU_AND;
              default: alu_op = hca_pkg::ALU_XOR;
            endcase
          end
          default:
          begin
            {upd_z, upd_cdc} = 2'b11;
            alu_op = ir_q[9] ? hca_pkg::ALU_ADD : hca_pkg::ALU_SUB;
          end
        endcase
      end
    endcase
  end

  // operand routing and mapped special registers
  always_comb
  begin
    bitn = ir_q[9:7];
    eff_addr = (ir_q[6:0] == hca_pkg::ADDR_INDIRECT) ? fsr_q[6:0] : ir_q[6:0];
    is_sfr = 1'b1;
    case (eff_addr)
      hca_pkg::ADDR_PC_LOW: sfr_val_d = pc_q[7:0];
      hca_pkg::ADDR_STATUS: sfr_val_d = {5'h00, flags_q};
      hca_pkg::ADDR_POINTER: sfr_val_d = fsr_q;
      hca_pkg::ADDR_PC_LATCH: sfr_val_d = {3'h0, pclath_q};
      hca_pkg::ADDR_INDIRECT: sfr_val_d = hca_pkg::BYTE_RESET;
      default:
      begin
        sfr_val_d = hca_pkg::BYTE_RESET;
        is_sfr = 1'b0;
      end
    endcase
    sfr_hit_d = sfr_hit_q;
    if (phase_q == hca_pkg::PH_TWO)
    begin
      sfr_hit_d = is_sfr;
    end
    else
    begin
      sfr_val_d = sfr_val_q;
    end
    file_val = sfr_hit_q ? sfr_val_q : dmem_rdata;
    op_a = sel_w ? w_q : (use_lit ? ir_q[7:0] : file_val);
    alu_out = alu_fn(alu_op, op_a, w_q, flags_q.carry_flag, bitn);
    res = alu_out[7:0];
    skip_now = (skip_zero && res == 8'h00) || (skip_clr && !op_a[bitn]) ||
               (skip_set && op_a[bitn]);
    pcl_write = wr_f && eff_addr == hca_pkg::ADDR_PC_LOW;
    flow_chg = skip_now || is_goto || is_call || is_return || pcl_write;
  end

  // data bus: read strobe in phase two, write strobe in phase four
  always_comb
  begin
    dbus.rd_en = (phase_q == hca_pkg::PH_TWO) && !is_sfr;
    dbus.rd_addr = eff_addr;
    dbus.wr_en = (phase_q == hca_pkg::PH_FOUR) && wr_f && !is_sfr;
    dbus.wr_addr = eff_addr;
    dbus.wr_data = res;
  end

  hca_dmem #(
    .DEPTH(hca_pkg::DMEM_DEPTH)
  ) u_dmem (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .dbus_i(dbus),
    .rd_data_o(dmem_rdata)
  );

  // phase sequencer, clock divided by four
  always_comb
  begin
    case (phase_q)
      hca_pkg::PH_ONE: phase_d = hca_pkg::PH_TWO;
      hca_pkg::PH_TWO: phase_d = hca_pkg::PH_THREE;
      hca_pkg::PH_THREE: phase_d = hca_pkg::PH_FOUR;
      default: phase_d = hca_pkg::PH_ONE;
    endcase
  end

  // commit at the end of phase four: fetch, pc, stack, w, flags, specials
  always_comb
  begin
    ir_d = ir_q;
    pc_d = pc_q;
    stack_d = stack_q;
    sp_d = sp_q;
    w_d = w_q;
    flags_d = flags_q;
    fsr_d = fsr_q;
    pclath_d = pclath_q;
    if (phase_q == hca_pkg::PH_FOUR)
    begin
      ir_d = pm_data_i;
      pc_d = pc_q + 13'h0001;
      if (wr_w || is_return && use_lit)
      begin
        w_d = (is_return && use_lit) ? ir_q[7:0] : res;
      end
      if (wr_f)
      begin
        case (eff_addr)
          hca_pkg::ADDR_STATUS: flags_d = res[2:0];
          hca_pkg::ADDR_POINTER: fsr_d = res;
          hca_pkg::ADDR_PC_LATCH: pclath_d = res[4:0];
          default: fsr_d = fsr_q;
        endcase
      end
      if (upd_z)
      begin
        flags_d.zero_flag = (res == 8'h00);
      end
      if (upd_cdc || upd_c)
      begin
        flags_d.carry_flag = alu_out[9];
      end
      if (upd_cdc)
      begin
        flags_d.nibble_overflow_flag = alu_out[8];
      end
      if (is_call)
      begin
        stack_d[sp_q] = pc_q;
        sp_d = sp_q + 3'h1;
      end
      if (flow_chg)
      begin
        ir_d = hca_pkg::NOP_WORD;
        if (is_goto || is_call)
        begin
          pc_d = {pclath_q[4:3], ir_q[10:0]};
        end
        else if (is_return)
        begin
          pc_d = stack_q[sp_q - 3'h1];
          sp_d = sp_q - 3'h1;
        end
        else if (pcl_write)
        begin
          pc_d = {pclath_q, res};
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      phase_q <= hca_pkg::PH_ONE;
      ir_q <= hca_pkg::NOP_WORD;
      pc_q <= hca_pkg::PC_RESET;
      for (int i = 0; i < hca_pkg::STACK_DEPTH; i++)
      begin
        stack_q[i] <= hca_pkg::PC_RESET;
      end
      sp_q <= 3'h0;
      w_q <= hca_pkg::W_RESET;
      flags_q <= 3'h0;
      fsr_q <= hca_pkg::BYTE_RESET;
      pclath_q <= 5'h00;
      sfr_hit_q <= 1'b0;
      sfr_val_q <= hca_pkg::BYTE_RESET;
    end
    else
    begin
      phase_q <= phase_d;
      ir_q <= ir_d;
      pc_q <= pc_d;
      stack_q <= stack_d;
      sp_q <= sp_d;
      w_q <= w_d;
      flags_q <= flags_d;
      fsr_q <= fsr_d;
      pclath_q <= pclath_d;
      sfr_hit_q <= sfr_hit_d;
      sfr_val_q <= sfr_val_d;
    end
  end

  // outputs straight from registers
  assign pm_addr_o = pc_q[PM_AW-1:0];
  assign phase_o = phase_q;
  assign w_o = w_q;
  assign flags_o = flags_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_phase_ring;
    phase_q == hca_pkg::PH_ONE |=> phase_q == hca_pkg::PH_TWO ##1
      phase_q == hca_pkg::PH_THREE ##1 phase_q == hca_pkg::PH_FOUR ##1 phase_q == hca_pkg::PH_ONE;
  endproperty
  a_phase_ring: assert property (p_phase_ring) else $error("phase ring broken");

  property p_fetch_load;
    phase_q == hca_pkg::PH_FOUR && !flow_chg |=> ir_q == $past(pm_data_i);
  endproperty
  a_fetch_load: assert property (p_fetch_load) else $error("fetched word not loaded");

  property p_pc_step;
    phase_q != hca_pkg::PH_FOUR |=> $stable(pc_q);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc moved mid cycle");

  property p_flush;
    phase_q == hca_pkg::PH_FOUR && flow_chg |=> ir_q == hca_pkg::NOP_WORD;
  endproperty
  a_flush: assert property (p_flush) else $error("flow change not flushed");

  property p_read_phase;
    dbus.rd_en |-> phase_q == hca_pkg::PH_TWO ##1 phase_q == hca_pkg::PH_THREE;
  endproperty
  a_read_phase: assert property (p_read_phase) else $error("read outside phase two");

  property p_write_phase;
    dbus.wr_en |-> phase_q == hca_pkg::PH_FOUR && wr_f;
  endproperty
  a_write_phase: assert property (p_write_phase) else $error("write outside phase four");

  property p_zero;
    phase_q == hca_pkg::PH_FOUR && upd_z |=> flags_q.zero_flag == ($past(res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_carry;
    phase_q == hca_pkg::PH_FOUR && upd_cdc |=>
      flags_q.carry_flag == $past(alu_out[9]) &&
      flags_q.nibble_overflow_flag == $past(alu_out[8]);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flags wrong");

  property p_w_hold;
    phase_q != hca_pkg::PH_FOUR |=> $stable(w_q);
  endproperty
  a_w_hold: assert property (p_w_hold) else $error("w changed mid cycle");

  c_goto: cover property (phase_q == hca_pkg::PH_FOUR && is_goto);
  c_skip: cover property (phase_q == hca_pkg::PH_FOUR && skip_now);
  c_borrow: cover property (phase_q == hca_pkg::PH_FOUR && alu_op == hca_pkg::ALU_SUB &&
                            !alu_out[9]);
  c_indirect: cover property (dbus.wr_en && ir_q[6:0] == hca_pkg::ADDR_INDIRECT);

endmodule

`default_nettype wire

// File: hca_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

module hca_core_tb;

  // clock, reset and design ports
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [13:0] pm_data_i = 14'h0000;
  logic [11:0] pm_addr_o;
  hca_pkg::hca_phase_t phase_o;
  logic [7:0] w_o;
  hca_pkg::hca_flags_t flags_o;

  // program store, counters
  logic [13:0] rom [0:4095];
  int n_mismatch = 0;
  int comparisons = 0;
  int ecnt = 0;
  int cyc = 0;

  hca_core #(
    .PM_WORDS(4096)
  ) u_dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i),
    .phase_o(phase_o),
    .w_o(w_o),
    .flags_o(flags_o)
  );

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  // program word presented off the sampling edge
  always @(negedge clk_i)
  begin
    pm_data_i <= rom[pm_addr_o];
  end

  // edges since reset release, and hang guard
  always @(posedge clk_i)
  begin
    if (reset_i)
      ecnt <= 0;
    else
      ecnt <= ecnt + 1;
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // clear the program to no-ops
  task automatic clear_rom();
    foreach (rom[i])
      rom[i] = 14'h0000;
  endtask

  // reset held 20 cycles, released on a falling edge
  task automatic reset_dut();
    @(negedge clk_i);
    reset_i <= 1'b1;
    repeat (20) @(negedge clk_i);
    reset_i <= 1'b0;
  endtask

  // wait for the falling edge after rising edge n
  task automatic at_edge(input int n);
    while (ecnt < n)
      @(negedge clk_i);
  endtask

  // expected {result, zero, nibble, carry} of a + b or a - b
  function automatic logic [10:0] ref_arith(input logic [7:0] a, input logic [7:0] b,
                                            input logic sub);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] bb;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
    n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
  endfunction

  // reset values, phase rotation, one fetch per four clocks
  task automatic t_reset_phases();
    clear_rom();
    reset_dut();
    check("w_rst", w_o, 16'h0000);
    check("flags_rst", flags_o, 16'h0000);
    for (int k = 0; k < 12; k++)
    begin
      at_edge(k);
      check("phase", phase_o, k % 4);
      check("pm_addr", pm_addr_o, k / 4);
    end
    check("addr_width", $bits(u_dut.pm_addr_o), 16'h000c);
  endtask

  // literal add and subtract over flag corner cases
  task automatic t_arith(input logic sub);
    logic [7:0] wv [4];
    logic [7:0] kv [4];
    logic [10:0] e;
    if (sub)
    begin
      wv = '{8'h05, 8'h03, 8'h10, 8'h01};
      kv = '{8'h03, 8'h05, 8'h10, 8'h10};
    end
    else
    begin
      wv = '{8'h0f, 8'hff, 8'h80, 8'h12};
      kv = '{8'h01, 8'h01, 8'h80, 8'h34};
    end
    clear_rom();
    for (int i = 0; i < 4; i++)
    begin
      rom[2 * i] = {6'h30, wv[i]};
      rom[2 * i + 1] = {sub ? 6'h3c : 6'h3e, kv[i]};
    end
    reset_dut();
    for (int i = 0; i < 4; i++)
    begin
      e = ref_arith(sub ? kv[i] : wv[i], sub ? wv[i] : kv[i], sub);
      at_edge(4 * (2 * i + 3) - 1);
      check("w_pre", w_o, wv[i]);
      at_edge(4 * (2 * i + 3));
      check("w_arith", w_o, e[10:3]);
      check("flags_arith", flags_o, e[2:0]);
    end
  endtask

  // logic operations touch the zero flag only
  task automatic t_logic();
    logic [7:0] av [3];
    logic [7:0] kv [3];
    logic [7:0] r [3];
    av = '{8'h00, 8'hf0, 8'h5a};
    kv = '{8'h00, 8'h0f, 8'hff};
    r = '{8'h00, 8'h00, 8'ha5};
    clear_rom();
    for (int i = 0; i < 3; i++)
    begin
      rom[2 * i] = {6'h30, av[i]};
      rom[2 * i + 1] = {4'he, i[1:0], kv[i]};
    end
    reset_dut();
    for (int i = 0; i < 3; i++)
    begin
      at_edge(4 * (2 * i + 3));
      check("w_logic", w_o, r[i]);
      check("flags_logic", flags_o, {r[i] == 8'h00, 2'b00});
    end
  endtask

  // file register operand, destination select, read back
  task automatic t_file();
    clear_rom();
    rom[0] = 14'h3025;
    rom[1] = 14'h00a0;
    rom[2] = 14'h3010;
    rom[3] = 14'h0720;
    rom[4] = 14'h07a0;
    rom[5] = 14'h0820;
    reset_dut();
    at_edge(19);
    check("w_before_add", w_o, 16'h0010);
    at_edge(20);
    check("w_addwf", w_o, 16'h0035);
    check("flags_addwf", flags_o, 16'h0000);
    at_edge(24);
    check("w_kept", w_o, 16'h0035);
    at_edge(28);
    check("w_movf", w_o, 16'h005a);
    check("flags_movf", flags_o, 16'h0000);
  endtask

  // jump costs two cycles and drops the prefetched word
  task automatic t_branch();
    clear_rom();
    rom[0] = 14'h2805;
    rom[1] = 14'h3011;
    rom[5] = 14'h3022;
    reset_dut();
    at_edge(8);
    check("pm_jump", pm_addr_o, 16'h0005);
    at_edge(12);
    check("w_bubble", w_o, 16'h0000);
    check("pm_next", pm_addr_o, 16'h0006);
    at_edge(16);
    check("w_target", w_o, 16'h0022);
    check("pm_after", pm_addr_o, 16'h0007);
  endtask

  // pointer, status read, rotates through carry, swap, bit set
  task automatic t_ops();
    clear_rom();
    rom[0] = 14'h3030;
    rom[1] = 14'h0084;
    rom[2] = 14'h3097;
    rom[3] = 14'h0080;
    rom[4] = 14'h0cb0;
    rom[5] = 14'h0803;
    rom[6] = 14'h0d30;
    rom[7] = 14'h0e00;
    rom[8] = 14'h17b0;
    rom[9] = 14'h0830;
    reset_dut();
    at_edge(24);
    check("flags_rrc", flags_o, 16'h0001);
    at_edge(28);
    check("w_status", w_o, 16'h0001);
    at_edge(32);
    check("w_rlc", w_o, 16'h0097);
    check("flags_rlc", flags_o, 16'h0000);
    at_edge(36);
    check("w_swap", w_o, 16'h00b4);
    at_edge(44);
    check("w_bset", w_o, 16'h00cb);
  endtask

  // call, literal return, decrement and skip on zero
  task automatic t_flow();
    clear_rom();
    rom[0] = 14'h2008;
    rom[1] = 14'h00a1;
    rom[2] = 14'h0ba1;
    rom[3] = 14'h0ba1;
    rom[4] = 14'h3055;
    rom[5] = 14'h3077;
    rom[6] = 14'h2806;
    rom[8] = 14'h3402;
    reset_dut();
    at_edge(8);
    check("pm_call", pm_addr_o, 16'h0008);
    at_edge(16);
    check("w_retlw", w_o, 16'h0002);
    check("pm_return", pm_addr_o, 16'h0001);
    at_edge(32);
    check("pm_skip", pm_addr_o, 16'h0005);
    at_edge(36);
    check("w_skipped", w_o, 16'h0002);
    at_edge(40);
    check("w_after_skip", w_o, 16'h0077);
    check("flags_skip", flags_o, 16'h0000);
  endtask

  // main sequence
  initial
  begin
    clear_rom();
    t_reset_phases();
    t_arith(1'b0);
    t_arith(1'b1);
    t_logic();
    t_file();
    t_branch();
    t_ops();
    t_flow();
    stop_test();
  end

endmodule

`default_nettype wire
